// ===== verilog/isoch_chan_mask_and_irq_events.sv
// channel receive mask plus main and isochronous interrupt event/mask pairs
// assumes all event sources are on CORE_CLK_I and the host uses a word port
`timescale 1ns/100ps
// Summary of operation
// - high set address enables channels 32 to 63
// - low set address enables channels 0 to 31
// - clear addresses disable; zero bits change nothing
// - mask reads show enabled channels as ones
// - mask survives bus reset; software initialises it
// - dma and device interrupt classes both reported
// - event and mask have set/clear addresses
// - irq asserted while event and mask overlap
// - event sets on edge or write, sticky
// - set reads raw, clear reads masked event
// - four isochronous event/mask registers behave alike
// - bit 26 marks phy register byte ready
// - bit 25 overlong cycle, drops root enable
// - bit 24 fatal error blocks offender events
// - bit 23 cycle time mismatch or write
// - bit 22 no cycle start between ticks
// - bit 21 seconds bit six changed
// - bit 20 cycle count lsb toggled
// - bus reset clears scan done bit
// - bits 7,6 are unlatched isochronous summaries
module isoch_chan_mask_and_irq_events #(
    parameter int NCTX         = 8,
    parameter int OVERLONG_CNT = irq_ctl_pkg::OVERLONG_CYCLES
) (
    input  wire logic            CORE_CLK_I,
    input  wire logic            RST_N_I,
    input  wire logic            REG_WR_I,
    input  wire logic            REG_RD_I,
    input  wire logic [7:0]      REG_ADDR_I,
    input  wire logic [31:0]     REG_WDATA_I,
    output logic      [31:0]     REG_RDATA_O,
    output logic                 REG_ACK_O,
    input  wire logic [31:0]     LINK_EVT_I,
    input  wire logic            PHY_REG_BYTE_READY_I,
    input  wire logic [3:0]      CONTEXT_HALTED_I,
    input  wire logic [NCTX-1:0] ISO_TX_HALTED_I,
    input  wire logic [NCTX-1:0] ISO_RX_HALTED_I,
    input  wire logic [NCTX-1:0] ISO_TX_EVT_I,
    input  wire logic [NCTX-1:0] ISO_RX_EVT_I,
    input  wire logic            CYCLE_TIME_MISMATCH_I,
    input  wire logic            CYCLE_TIMER_WRITE_I,
    input  wire logic            CYCLE_BEGIN_SENT_I,
    input  wire logic            CYCLE_BEGIN_SEEN_I,
    input  wire logic            SUBACTION_GAP_I,
    input  wire logic [6:0]      CYCLE_SECONDS_I,
    input  wire logic            CYCLE_COUNT_LSB_I,
    output logic [63:0]          CHAN_RX_EN_O,
    output logic                 ROOT_CYCLE_SOURCE_EN_O,
    output logic                 IRQ_O
);
    localparam int EW = 32 + 2 * NCTX; // width of the edge detector

    // all module state in one record
    typedef struct packed {
        logic [63:0]               chan_mask;  // receive enable per channel
        logic [31:0]               evt;        // latched main events
        logic [31:0]               emask;      // main enable mask
        logic [NCTX-1:0]           itx_evt;    // iso transmit events
        logic [NCTX-1:0]           itx_mask;   // iso transmit mask
        logic [NCTX-1:0]           irx_evt;    // iso receive events
        logic [NCTX-1:0]           irx_mask;   // iso receive mask
        logic [3:0]                off_ctx;    // async contexts that halted
        logic [NCTX-1:0]           off_tx;     // iso tx contexts that halted
        logic [NCTX-1:0]           off_rx;     // iso rx contexts that halted
        logic                      root_en;    // cycle source enable
        logic                      ovl_run;    // overlong timer armed
        logic [irq_ctl_pkg::OVERLONG_CNT_W-1:0] ovl_cnt;
        logic                      tick_armed; // first tick seen
        logic                      begin_seen; // cycle start since last tick
        logic                      sec6_prev;  // last seconds bit six
        logic                      lsb_prev;   // last cycle count lsb
        logic [31:0]               rdata;      // read data register
        logic                      ack;        // access acknowledge
    } state_t;

    state_t s_q;
    state_t s_d;

    // combinational helpers
    logic [EW-1:0]   src_lvl;   // source levels to edge detector
    logic [EW-1:0]   src_rise;  // asserting edges
    logic [31:0]     main_src;  // main event source levels
    logic [31:0]     evt_view;  // event incl. summary bits
    logic            rx_sum;    // iso receive summary
    logic            tx_sum;    // iso transmit summary
    logic            ovl_fire;  // overlong timer expiry
    logic            tick;      // new cycle marker
    logic            sec6_chg;  // seconds bit six changed
    logic            missed;    // missed cycle this tick

    // timer limit cast once to counter width
    localparam logic [irq_ctl_pkg::OVERLONG_CNT_W-1:0] OVL_LIMIT =
        irq_ctl_pkg::OVERLONG_CNT_W'(OVERLONG_CNT - 1);

    // cycle and seconds change detection from registered copies
    assign tick     = CYCLE_COUNT_LSB_I ^ s_q.lsb_prev;
    assign sec6_chg = CYCLE_SECONDS_I[irq_ctl_pkg::SECONDS_WATCH_BIT] ^ s_q.sec6_prev;
    // a tick with no cycle start since the previous one is a lost cycle
    assign missed   = tick & s_q.tick_armed & ~s_q.begin_seen & ~CYCLE_BEGIN_SEEN_I;
    // expiry only while the cycle source stays enabled
    assign ovl_fire = s_q.ovl_run & s_q.root_en & (s_q.ovl_cnt == OVL_LIMIT);

    // summaries are not latched, they follow the iso registers
    assign rx_sum = |(s_q.irx_evt & s_q.irx_mask);
    assign tx_sum = |(s_q.itx_evt & s_q.itx_mask);

    // main source levels, generic dma and link events pass by mask
    always_comb
    begin
        main_src = LINK_EVT_I & irq_ctl_pkg::EVT_GENERIC_MASK;
        main_src[irq_ctl_pkg::PHY_REG_BYTE_READY_BIT]  = PHY_REG_BYTE_READY_I;
        main_src[irq_ctl_pkg::OVERLONG_CYCLE_BIT]      = ovl_fire;
        main_src[irq_ctl_pkg::FATAL_ERROR_BIT]         =
            (|CONTEXT_HALTED_I) | (|ISO_TX_HALTED_I) | (|ISO_RX_HALTED_I);
        main_src[irq_ctl_pkg::CYCLE_TIME_MISMATCH_BIT] =
            CYCLE_TIME_MISMATCH_I | CYCLE_TIMER_WRITE_I;
        main_src[irq_ctl_pkg::MISSED_CYCLE_BIT]        = missed;
        main_src[irq_ctl_pkg::SECONDS_BIT6_TOGGLE_BIT] = sec6_chg;
        main_src[irq_ctl_pkg::NEW_CYCLE_TICK_BIT]      = tick;
    end

    assign src_lvl = {ISO_RX_EVT_I, ISO_TX_EVT_I, main_src};

    // edges of all sources in one shared detector
    event_rise #(
        .W (EW)
    ) u_rise (
        .CORE_CLK_I (CORE_CLK_I),
        .RST_N_I    (RST_N_I),
        .lvl_i      (src_lvl),
        .rise_o     (src_rise)
    );

    // event view with summaries merged, reserved bits forced low
    always_comb
    begin
        evt_view = s_q.evt & irq_ctl_pkg::EVT_LATCH_MASK;
        evt_view[irq_ctl_pkg::ISO_RX_SUMMARY_BIT] = rx_sum;
        evt_view[irq_ctl_pkg::ISO_TX_SUMMARY_BIT] = tx_sum;
    end

    // next state: register writes, hardware events, timers, reads
    always_comb
    begin
        logic [31:0]     wr_set;    // ones written to main event set
        logic [31:0]     wr_clr;    // ones written to main event clear
        logic [31:0]     hw_set;    // hardware event edges after blocking
        logic [31:0]     blk;       // main bits blocked by fatal error
        logic [NCTX-1:0] tx_hw;     // iso tx edges after blocking
        logic [NCTX-1:0] rx_hw;     // iso rx edges after blocking
        logic [NCTX-1:0] tx_ws;     // iso tx event set write
        logic [NCTX-1:0] tx_wc;     // iso tx event clear write
        logic [NCTX-1:0] rx_ws;     // iso rx event set write
        logic [NCTX-1:0] rx_wc;     // iso rx event clear write
        logic [NCTX-1:0] wnarrow;   // write data cut to context width
        // every local starts defined so no path leaves a latch behind
        wr_set  = '0;
        wr_clr  = '0;
        hw_set  = '0;
        tx_hw   = '0;
        rx_hw   = '0;
        blk     = '0;
        tx_ws   = '0;
        tx_wc   = '0;
        rx_ws   = '0;
        rx_wc   = '0;
        wnarrow = REG_WDATA_I[NCTX-1:0];
        s_d     = s_q;
        s_d.ack = REG_WR_I | REG_RD_I;

        // register writes; only ones act, zeros leave bits alone, except at link control where a zero clears root_en
        if (REG_WR_I)
        begin
            unique case (REG_ADDR_I)
                irq_ctl_pkg::CHAN_MASK_HIGH_SET_OFS:
                    s_d.chan_mask[63:32] = s_q.chan_mask[63:32] | REG_WDATA_I;
                irq_ctl_pkg::CHAN_MASK_HIGH_CLEAR_OFS:
                    s_d.chan_mask[63:32] = s_q.chan_mask[63:32] & ~REG_WDATA_I;
                irq_ctl_pkg::CHAN_MASK_LOW_SET_OFS:
                    s_d.chan_mask[31:0] = s_q.chan_mask[31:0] | REG_WDATA_I;
                irq_ctl_pkg::CHAN_MASK_LOW_CLEAR_OFS:
                    s_d.chan_mask[31:0] = s_q.chan_mask[31:0] & ~REG_WDATA_I;
                irq_ctl_pkg::IRQ_EVENT_SET_OFS:
                    wr_set = REG_WDATA_I;
                irq_ctl_pkg::IRQ_EVENT_CLEAR_OFS:
                    wr_clr = REG_WDATA_I;
                irq_ctl_pkg::IRQ_MASK_SET_OFS:
                    s_d.emask = s_q.emask | (REG_WDATA_I & irq_ctl_pkg::EVT_IMPL_MASK);
                irq_ctl_pkg::IRQ_MASK_CLEAR_OFS:
                    s_d.emask = s_q.emask & ~REG_WDATA_I;
                irq_ctl_pkg::ISO_TX_EVENT_SET_OFS:
                    tx_ws = wnarrow;
                irq_ctl_pkg::ISO_TX_EVENT_CLEAR_OFS:
                    tx_wc = wnarrow;
                irq_ctl_pkg::ISO_TX_MASK_SET_OFS:
                    s_d.itx_mask = s_q.itx_mask | wnarrow;
                irq_ctl_pkg::ISO_TX_MASK_CLEAR_OFS:
                    s_d.itx_mask = s_q.itx_mask & ~wnarrow;
                irq_ctl_pkg::ISO_RX_EVENT_SET_OFS:
                    rx_ws = wnarrow;
                irq_ctl_pkg::ISO_RX_EVENT_CLEAR_OFS:
                    rx_wc = wnarrow;
                irq_ctl_pkg::ISO_RX_MASK_SET_OFS:
                    s_d.irx_mask = s_q.irx_mask | wnarrow;
                irq_ctl_pkg::ISO_RX_MASK_CLEAR_OFS:
                    s_d.irx_mask = s_q.irx_mask & ~wnarrow;
                irq_ctl_pkg::LINK_CTRL_OFS:
                    s_d.root_en = REG_WDATA_I[irq_ctl_pkg::ROOT_CYCLE_SOURCE_BIT];
                default:
                    s_d.ack = 1'b1; // unmapped write is acknowledged and dropped
            endcase
        end

        // offending contexts only block while the fatal bit stands
        if (s_q.evt[irq_ctl_pkg::FATAL_ERROR_BIT])
        begin
            blk[3:0] = s_q.off_ctx;
            blk[4]   = s_q.off_ctx[2]; // request packet follows its context
            blk[5]   = s_q.off_ctx[3]; // response packet follows its context
        end
        hw_set = src_rise[31:0] & ~blk;
        tx_hw  = src_rise[32 +: NCTX] &
                 ~(s_q.off_tx & {NCTX{s_q.evt[irq_ctl_pkg::FATAL_ERROR_BIT]}});
        rx_hw  = src_rise[32 + NCTX +: NCTX] &
                 ~(s_q.off_rx & {NCTX{s_q.evt[irq_ctl_pkg::FATAL_ERROR_BIT]}});

        // sticky events: set (hardware or software) wins over clear
        s_d.evt = ((s_q.evt & ~wr_clr) | wr_set | hw_set)
                  & irq_ctl_pkg::EVT_LATCH_MASK;
        // bus reset entry drops scan done in the same cycle
        if (hw_set[irq_ctl_pkg::SERIAL_BUS_RESET_BIT])
            s_d.evt[irq_ctl_pkg::NODE_ID_SCAN_DONE_BIT] = 1'b0;
        s_d.itx_evt = (s_q.itx_evt & ~tx_wc) | tx_ws | tx_hw;
        s_d.irx_evt = (s_q.irx_evt & ~rx_wc) | rx_ws | rx_hw;

        // remember offenders until the fatal bit ends cleared
        if (!s_d.evt[irq_ctl_pkg::FATAL_ERROR_BIT])
        begin
            s_d.off_ctx = CONTEXT_HALTED_I;
            s_d.off_tx  = ISO_TX_HALTED_I;
            s_d.off_rx  = ISO_RX_HALTED_I;
        end
        else
        begin
            s_d.off_ctx = s_q.off_ctx | CONTEXT_HALTED_I;
            s_d.off_tx  = s_q.off_tx | ISO_TX_HALTED_I;
            s_d.off_rx  = s_q.off_rx | ISO_RX_HALTED_I;
        end

        // overlong cycle timer: armed by a sent start, stopped by gap or reset
        // a gap in the same cycle as a sent start is ignored; the start wins
        if (CYCLE_BEGIN_SENT_I)
        begin
            s_d.ovl_run = 1'b1;
            s_d.ovl_cnt = '0;
        end
        else if (SUBACTION_GAP_I || src_lvl[irq_ctl_pkg::SERIAL_BUS_RESET_BIT] || ovl_fire)
            s_d.ovl_run = 1'b0;
        else if (s_q.ovl_run)
            s_d.ovl_cnt = s_q.ovl_cnt + 1'b1;
        // expiry overrides any software write of the enable
        if (ovl_fire)
            s_d.root_en = 1'b0;

        // cycle tracking for lost cycles and seconds rollover
        s_d.lsb_prev  = CYCLE_COUNT_LSB_I;
        s_d.sec6_prev = CYCLE_SECONDS_I[irq_ctl_pkg::SECONDS_WATCH_BIT];
        if (tick)
        begin
            s_d.tick_armed = 1'b1;
            s_d.begin_seen = 1'b0; // window restarts at every tick
        end
        else if (CYCLE_BEGIN_SEEN_I || CYCLE_BEGIN_SENT_I)
            s_d.begin_seen = 1'b1;

        // read data, registered one cycle after the strobe
        // reads have no side effects, so a handler may poll freely
        s_d.rdata = irq_ctl_pkg::WORD_RESET;
        if (REG_RD_I)
        begin
            unique case (REG_ADDR_I)
                irq_ctl_pkg::CHAN_MASK_HIGH_SET_OFS,
                irq_ctl_pkg::CHAN_MASK_HIGH_CLEAR_OFS:
                    s_d.rdata = s_q.chan_mask[63:32];
                irq_ctl_pkg::CHAN_MASK_LOW_SET_OFS,
                irq_ctl_pkg::CHAN_MASK_LOW_CLEAR_OFS:
                    s_d.rdata = s_q.chan_mask[31:0];
                irq_ctl_pkg::IRQ_EVENT_SET_OFS:
                    s_d.rdata = evt_view;
                irq_ctl_pkg::IRQ_EVENT_CLEAR_OFS:
                    s_d.rdata = evt_view & s_q.emask;
                irq_ctl_pkg::IRQ_MASK_SET_OFS,
                irq_ctl_pkg::IRQ_MASK_CLEAR_OFS:
                    s_d.rdata = s_q.emask;
                irq_ctl_pkg::ISO_TX_EVENT_SET_OFS:
                    s_d.rdata[NCTX-1:0] = s_q.itx_evt;
                irq_ctl_pkg::ISO_TX_EVENT_CLEAR_OFS:
                    s_d.rdata[NCTX-1:0] = s_q.itx_evt & s_q.itx_mask;
                irq_ctl_pkg::ISO_TX_MASK_SET_OFS,
                irq_ctl_pkg::ISO_TX_MASK_CLEAR_OFS:
                    s_d.rdata[NCTX-1:0] = s_q.itx_mask;
                irq_ctl_pkg::ISO_RX_EVENT_SET_OFS:
                    s_d.rdata[NCTX-1:0] = s_q.irx_evt;
                irq_ctl_pkg::ISO_RX_EVENT_CLEAR_OFS:
                    s_d.rdata[NCTX-1:0] = s_q.irx_evt & s_q.irx_mask;
                irq_ctl_pkg::ISO_RX_MASK_SET_OFS,
                irq_ctl_pkg::ISO_RX_MASK_CLEAR_OFS:
                    s_d.rdata[NCTX-1:0] = s_q.irx_mask;
                irq_ctl_pkg::LINK_CTRL_OFS:
                    s_d.rdata[irq_ctl_pkg::ROOT_CYCLE_SOURCE_BIT] = s_q.root_en;
                default:
                    s_d.rdata = irq_ctl_pkg::WORD_RESET; // unmapped reads zero
            endcase
        end
    end

    // state register; of the two resets only hard reset clears the channel mask,
    // a serial bus reset never touches it
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            s_q           <= '0;
            s_q.chan_mask <= irq_ctl_pkg::CHAN_MASK_RESET;
        end
        else
            s_q <= s_d;
    end

    // outputs
    assign CHAN_RX_EN_O           = s_q.chan_mask;
    assign ROOT_CYCLE_SOURCE_EN_O = s_q.root_en;
    assign REG_RDATA_O            = s_q.rdata;
    assign REG_ACK_O              = s_q.ack;
    // request follows the overlap; drops once software clears it
    assign IRQ_O                  = |(evt_view & s_q.emask);

endmodule

// ===== verilog/irq_ctl_pkg.sv
// package for the channel mask and interrupt event block
// assumes a 125 MHz core clock and a simple word-wide register port
package irq_ctl_pkg;

    // register byte offsets
    localparam logic [7:0] CHAN_MASK_HIGH_SET_OFS  = 8'h70;
    localparam logic [7:0] CHAN_MASK_HIGH_CLEAR_OFS = 8'h74;
    localparam logic [7:0] CHAN_MASK_LOW_SET_OFS   = 8'h78;
    localparam logic [7:0] CHAN_MASK_LOW_CLEAR_OFS = 8'h7c;
    localparam logic [7:0] IRQ_EVENT_SET_OFS       = 8'h80;
    localparam logic [7:0] IRQ_EVENT_CLEAR_OFS     = 8'h84;
    localparam logic [7:0] IRQ_MASK_SET_OFS        = 8'h88;
    localparam logic [7:0] IRQ_MASK_CLEAR_OFS      = 8'h8c;
    localparam logic [7:0] ISO_TX_EVENT_SET_OFS    = 8'h90;
    localparam logic [7:0] ISO_TX_EVENT_CLEAR_OFS  = 8'h94;
    localparam logic [7:0] ISO_TX_MASK_SET_OFS     = 8'h98;
    localparam logic [7:0] ISO_TX_MASK_CLEAR_OFS   = 8'h9c;
    localparam logic [7:0] ISO_RX_EVENT_SET_OFS    = 8'ha0;
    localparam logic [7:0] ISO_RX_EVENT_CLEAR_OFS  = 8'ha4;
    localparam logic [7:0] ISO_RX_MASK_SET_OFS     = 8'ha8;
    localparam logic [7:0] ISO_RX_MASK_CLEAR_OFS   = 8'hac;
    localparam logic [7:0] LINK_CTRL_OFS           = 8'hb0;

    // event, link control and seconds watch bit positions
    localparam int PHY_REG_BYTE_READY_BIT  = 26;
    localparam int OVERLONG_CYCLE_BIT      = 25;
    localparam int FATAL_ERROR_BIT         = 24;
    localparam int CYCLE_TIME_MISMATCH_BIT = 23;
    localparam int MISSED_CYCLE_BIT        = 22;
    localparam int SECONDS_BIT6_TOGGLE_BIT = 21;
    localparam int NEW_CYCLE_TICK_BIT      = 20;
    localparam int SERIAL_BUS_RESET_BIT    = 17;
    localparam int NODE_ID_SCAN_DONE_BIT   = 16;
    localparam int ISO_RX_SUMMARY_BIT      = 7;
    localparam int ISO_TX_SUMMARY_BIT      = 6;
    localparam int ROOT_CYCLE_SOURCE_BIT   = 0;
    localparam int SECONDS_WATCH_BIT       = 6;

    // field masks
    localparam logic [31:0] EVT_IMPL_MASK    = 32'h07fb_03ff;
    localparam logic [31:0] EVT_LATCH_MASK   = 32'h07fb_033f;
    localparam logic [31:0] EVT_GENERIC_MASK = 32'h000b_033f;

    // reset values
    localparam logic [63:0] CHAN_MASK_RESET = 64'h0;
    localparam logic [31:0] WORD_RESET      = 32'h0;

    // overlong cycle timer, least time rounded up to whole cycles
    localparam int CLK_PERIOD_PS    = 8000;
    localparam int OVERLONG_MIN_NS  = 115000;
    localparam int OVERLONG_CYCLES  = (OVERLONG_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int OVERLONG_CNT_W   = 16;

endpackage

// ===== verilog/event_rise.sv
// per-bit asserting-edge detector for event source levels
// assumes sources come from logic on the same clock
`timescale 1ns/100ps
module event_rise #(
    parameter int W = 8
) (
    input  wire logic         CORE_CLK_I,
    input  wire logic         RST_N_I,
    input  wire logic [W-1:0] lvl_i,
    output logic      [W-1:0] rise_o
);
    typedef struct packed {
        logic [W-1:0] prev; // last sampled level
    } rise_state_t;

    rise_state_t s_q;
    rise_state_t s_d;

    // rising edge per bit, one generate loop
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            assign rise_o[g] = lvl_i[g] & ~s_q.prev[g];
        end
    endgenerate

    // next state is just the current level
    always_comb
    begin
        s_d      = s_q;
        s_d.prev = lvl_i;
    end

    // prev starts high-free so a level held through reset fires once
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            s_q <= '0;
        else
            s_q <= s_d;
    end
endmodule

// ===== bench/irq_ctl_sva.sv
// checker bound to the channel mask and interrupt event block
// assumes one clock domain and a one-cycle registered register answer
`timescale 1ns/100ps
module irq_ctl_sva (
    input wire logic        CORE_CLK_I,
    input wire logic        RST_N_I,
    input wire logic        REG_WR_I,
    input wire logic        REG_RD_I,
    input wire logic [7:0]  REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic [31:0] REG_RDATA_O,
    input wire logic        REG_ACK_O,
    input wire logic [63:0] CHAN_RX_EN_O,
    input wire logic        IRQ_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);
    property p_ack; REG_ACK_O == ($past(REG_WR_I) | $past(REG_RD_I)); endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle after strobe");
    property p_hi_set; REG_WR_I && REG_ADDR_I == 8'h70 |=>
        CHAN_RX_EN_O == ($past(CHAN_RX_EN_O) | {$past(REG_WDATA_I), 32'h0}); endproperty
    a_hi_set: assert property (p_hi_set) else $error("high set wrong");
    property p_lo_set; REG_WR_I && REG_ADDR_I == 8'h78 |=>
        CHAN_RX_EN_O == ($past(CHAN_RX_EN_O) | {32'h0, $past(REG_WDATA_I)}); endproperty
    a_lo_set: assert property (p_lo_set) else $error("low set wrong");
    property p_lo_clr; REG_WR_I && REG_ADDR_I == 8'h7c |=>
        CHAN_RX_EN_O == ($past(CHAN_RX_EN_O) & ~{32'h0, $past(REG_WDATA_I)}); endproperty
    a_lo_clr: assert property (p_lo_clr) else $error("low clear wrong");
    // mask moves only on a write to an address in the 0x70 to 0x7f range
    property p_hold; !(REG_WR_I && REG_ADDR_I[7:4] == 4'h7) |=> $stable(CHAN_RX_EN_O); endproperty
    a_hold: assert property (p_hold) else $error("mask moved");
    property p_irq_off; REG_WR_I && REG_ADDR_I == 8'h8c && REG_WDATA_I == 32'hffff_ffff |=> !IRQ_O; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq with empty mask");
    property p_rd_masked; REG_RD_I && REG_ADDR_I == 8'h84 |=> (REG_RDATA_O != 32'h0) == $past(IRQ_O); endproperty
    a_rd_masked: assert property (p_rd_masked) else $error("masked read disagrees with irq");
    property p_rsvd; REG_RD_I && REG_ADDR_I[7:3] == 5'h10 |=> (REG_RDATA_O & 32'hf804_fc00) == 32'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved event bit set");
    c_irq_rd: cover property (IRQ_O && REG_RD_I);
    c_clr_wr: cover property (REG_WR_I && REG_ADDR_I == 8'h84);
    c_irq_fall: cover property ($fell(IRQ_O));
endmodule

// ===== bench/host_model.sv
// host software model on the block's word register port
// assumes strobes are taken at a rising edge and answered one cycle later
`timescale 1ns/100ps
module host_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic        ack_i,
    output logic             wr_o,
    output logic             rd_o,
    output logic [7:0]       addr_o,
    output logic [31:0]      wdata_o
);
    initial {wr_o, rd_o, addr_o, wdata_o} = '0;
    // one word access; strobe lasts one cycle, answer taken in the ack cycle
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic k);
        @(posedge clk_i);
        wr_o <= w;
        rd_o <= !w;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        {wr_o, rd_o} <= 2'b00;
        #1;
        q = rdata_i;
        k = ack_i;
    endtask
    // service routine: fetch raw events, write the same value to clear
    task automatic service(output logic [31:0] ev);
        logic        k;
        logic [31:0] x;
        xfer(1'b0, 8'h80, 32'h0, ev, k);
        xfer(1'b1, 8'h84, ev, x, k);
    endtask
endmodule

// ===== bench/isoch_chan_mask_and_irq_events_tb.sv
// self-checking bench for the channel mask and interrupt event block
// assumes host_model drives the register port; irq_ctl_sva is bound below
`timescale 1ns/100ps
module isoch_chan_mask_and_irq_events_tb;
    logic        clk, rst_n, wr, rd, ack, irq, root_en, phy, mis, twr, sent, lsb;
    logic [7:0]  addr, rx_evt;
    logic [6:0]  secs;
    logic [3:0]  halt;
    logic [31:0] wdata, rdata, link, q;
    logic [63:0] chan;
    logic [31:0] m [10] = '{32'h0010_0000, 32'h0040_0000, 32'h0400_0000, 32'h0080_0000, 32'h0080_0000,
                            32'h0020_0000, 32'h0200_0000, 32'h0000_0080, 32'h0100_0000, 32'h0003_0000};
    int          error_cnt, n_compared;
    host_model u_host (.clk_i(clk), .rdata_i(rdata), .ack_i(ack), .wr_o(wr), .rd_o(rd), .addr_o(addr),
                       .wdata_o(wdata));
    isoch_chan_mask_and_irq_events #(.OVERLONG_CNT(20)) dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .REG_WR_I(wr),
        .REG_RD_I(rd), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_ACK_O(ack),
        .LINK_EVT_I(link), .PHY_REG_BYTE_READY_I(phy), .CONTEXT_HALTED_I(halt), .ISO_TX_HALTED_I(8'h00),
        .ISO_RX_HALTED_I(8'h00), .ISO_TX_EVT_I(rx_evt), .ISO_RX_EVT_I(rx_evt), .CYCLE_TIME_MISMATCH_I(mis),
        .CYCLE_TIMER_WRITE_I(twr), .CYCLE_BEGIN_SENT_I(sent), .CYCLE_BEGIN_SEEN_I(1'b0), .SUBACTION_GAP_I(1'b0),
        .CYCLE_SECONDS_I(secs), .CYCLE_COUNT_LSB_I(lsb), .CHAN_RX_EN_O(chan), .ROOT_CYCLE_SOURCE_EN_O(root_en),
        .IRQ_O(irq));
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        logic        k;
        logic [31:0] x;
        u_host.xfer(1'b1, a, d, x, k);
        chk(64'(k), 64'h1);
    endtask
    task automatic rd32(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
        logic k;
        u_host.xfer(1'b0, a, 32'h0, q, k);
        chk({31'h0, k, q & msk}, {32'h1, e});
    endtask
    // raise one event source; level sources drop again after one cycle
    task automatic src(input int k);
        @(posedge clk);
        case (k)
            0, 1: lsb <= ~lsb;
            2: phy <= 1'b1;
            3: mis <= 1'b1;
            4: twr <= 1'b1;
            5: secs[6] <= 1'b1;
            6: sent <= 1'b1;
            7: rx_evt[0] <= 1'b1;
            8: halt[0] <= 1'b1;
            default: link[17] <= 1'b1;
        endcase
        @(posedge clk);
        {phy, mis, twr, sent, rx_evt, link, halt} <= '0;
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // hang guard well beyond the few hundred cycles the sequence needs
    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        summarize();
    end
    initial
    begin
        {rst_n, phy, mis, twr, sent, lsb, rx_evt, secs, link, halt} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        wr32(8'h78, 32'ha5a5_a5a5);
        wr32(8'h70, 32'hffff_0000);
        wr32(8'h7c, 32'h0000_0005);
        wr32(8'h74, 32'h0001_0000);
        wr32(8'h78, 32'h0000_0000);
        wr32(8'hfc, 32'hffff_ffff);
        rd32(8'h7c, '1, 32'ha5a5_a5a0);
        rd32(8'h70, '1, 32'hfffe_0000);
        rd32(8'hfc, '1, 32'h0);
        chk(chan, 64'hfffe_0000_a5a5_a5a0);
        $display("test mask done");
        wr32(8'h84, '1);
        wr32(8'h8c, '1);
        wr32(8'h80, '1);
        rd32(8'h80, '1, 32'h07fb_033f);
        chk(64'(irq), 64'h0);
        wr32(8'h88, 32'h0400_0000);
        chk(64'(irq), 64'h1);
        rd32(8'h84, '1, 32'h0400_0000);
        u_host.service(q);
        chk({32'h0, q}, 64'h07fb_033f);
        chk(64'(irq), 64'h0);
        wr32(8'ha8, 32'h1);
        wr32(8'ha0, '1);
        rd32(8'ha4, '1, 32'h1);
        rd32(8'h80, 32'hc0, 32'h80);
        wr32(8'ha4, '1);
        rd32(8'ha0, '1, 32'h0);
        $display("test events done");
        wr32(8'hb0, 32'h1);
        for (int i = 0; i < 10; i++)
        begin
            wr32(8'h84, '1);
            if (i == 9)
                wr32(8'h80, 32'h0001_0000);
            src(i);
            repeat (24) @(posedge clk);
            rd32(8'h80, m[i], (i == 9) ? 32'h2_0000 : m[i]);
        end
        chk({root_en, chan[62:0]}, 64'h7ffe_0000_a5a5_a5a0);
        $display("test sources done");
        summarize();
    end
endmodule
bind isoch_chan_mask_and_irq_events irq_ctl_sva u_sva (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
    .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
    .REG_RDATA_O(REG_RDATA_O), .REG_ACK_O(REG_ACK_O), .CHAN_RX_EN_O(CHAN_RX_EN_O), .IRQ_O(IRQ_O));
